// *** src/scs_clock_control.v ***
// system clock source selection, prescaler and power-saving gating control
//
// Contract
// - slow source RC/crystal; change only in fast mode
// - fast source RC/crystal; change only in slow mode
// - fast crystal selected drives high oscillator gain
// - slow halt enable plus power-down stops slow clock
// - peripheral stop bit gates timers, serial in idle
// - fast stop halts fast osc in slow or idle; change in slow only
// - system clock select changes only while fast running
// - divider codes 16,4,2,1; resets to 11
// - new divider ratio applies within 16 cycles
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
`include "scs_consts.vh"

module scs_clock_control (
  // clock, reset and clock enable
  input wire MCLK_IN,
  input wire RST_IN,
  input wire CE_IN,
  // register port
  input wire [`SCS_ADDR_W-1:0] REG_ADDR_IN,
  input wire [`SCS_DATA_W-1:0] REG_WDATA_IN,
  input wire REG_WR_IN,
  input wire REG_RD_IN,
  output reg [`SCS_DATA_W-1:0] REG_RDATA_OUT,
  // operating mode from the core
  input wire POWER_DOWN_BIT_IN,
  input wire IDLE_MODE_IN,
  // oscillator controls
  output reg SLOW_CRYSTAL_EN_OUT,
  output reg SLOW_OSC_RUN_OUT,
  output reg FAST_CRYSTAL_EN_OUT,
  output reg FAST_XTAL_HIGH_GAIN_OUT,
  output reg FAST_OSC_RUN_OUT,
  // system and peripheral clock controls
  output reg SYS_CLK_FAST_SEL_OUT,
  output wire SYS_CLK_TICK_OUT,
  output reg PERIPH_CLK_EN_OUT
);

  // clock_control fields
  reg slow_source_sel_reg; // 0 internal rc, 1 crystal
  reg fast_source_sel_reg; // 0 internal rc, 1 crystal
  reg slow_clk_halt_en_reg; // stop slow clock on power-down
  reg idle_periph_clk_stop_reg; // gate peripherals in idle
  reg fast_osc_stop_reg; // stop fast osc in slow or idle
  reg sys_clk_fast_sel_reg; // 0 slow, 1 fast
  reg [1:0] sys_clk_divider_reg; // prescaler code

  // next values of the fields
  reg slow_source_sel_next;
  reg fast_source_sel_next;
  reg slow_clk_halt_en_next;
  reg idle_periph_clk_stop_next;
  reg fast_osc_stop_next;
  reg sys_clk_fast_sel_next;
  reg [1:0] sys_clk_divider_next;

  // decoded register port strobes
  reg ctl_wr;
  reg ctl_rd;

  // register image as software sees it
  wire [`SCS_DATA_W-1:0] ctl_image;

  // gating terms computed from the current fields
  reg slow_run_next;
  reg fast_run_next;
  reg periph_en_next;

  // operating mode as the write restrictions see it
  wire fast_mode; // fast clock drives the system
  wire slow_mode; // slow clock drives the system
  wire fast_osc_free; // fast oscillator not held stopped

  // write data split into the register fields
  wire wr_slow_source_sel; // new slow source choice
  wire wr_fast_source_sel; // new fast source choice
  wire wr_slow_clk_halt_en; // new slow halt enable
  wire wr_idle_periph_clk_stop; // new idle peripheral gate
  wire wr_fast_osc_stop; // new fast oscillator stop
  wire wr_sys_clk_fast_sel; // new system clock choice
  wire [1:0] wr_sys_clk_divider; // new prescaler code

  // per-field write permission, judged on the value before the write
  reg slow_source_wr_ok; // slow source writable
  reg fast_source_wr_ok; // fast source writable
  reg fast_osc_stop_wr_ok; // fast stop writable
  reg sys_clk_sel_wr_ok; // system select writable

  // power-saving requests ahead of the registered run enables
  reg slow_halt_req; // power-down with slow halt enabled
  reg fast_stop_req; // fast stop in slow or idle operation
  reg periph_gate_req; // idle with peripheral gating enabled

  // crystal pin and gain controls ahead of their flip-flops
  reg slow_xtal_next; // slow pins become crystal pins
  reg fast_xtal_next; // fast pins become crystal pins
  reg fast_gain_next; // high oscillator gain for the fast crystal

  // the port address selects the control register
  wire ctl_hit;

  // address match for the single mapped register
  assign ctl_hit = (REG_ADDR_IN == `SCS_CLOCK_CONTROL_ADDR);

  // mode decode from the stored select and stop bits
  assign fast_mode = sys_clk_fast_sel_reg;
  assign slow_mode = !sys_clk_fast_sel_reg;
  assign fast_osc_free = !fast_osc_stop_reg;

  // pick the fields out of the write data
  assign wr_slow_source_sel = REG_WDATA_IN[`SCS_SLOW_SOURCE_SEL_BIT];
  assign wr_fast_source_sel = REG_WDATA_IN[`SCS_FAST_SOURCE_SEL_BIT];
  assign wr_slow_clk_halt_en = REG_WDATA_IN[`SCS_SLOW_CLK_HALT_EN_BIT];
  assign wr_idle_periph_clk_stop = REG_WDATA_IN[`SCS_IDLE_PERIPH_CLK_STOP_BIT];
  assign wr_fast_osc_stop = REG_WDATA_IN[`SCS_FAST_OSC_STOP_BIT];
  assign wr_sys_clk_fast_sel = REG_WDATA_IN[`SCS_SYS_CLK_FAST_SEL_BIT];
  assign wr_sys_clk_divider = REG_WDATA_IN[`SCS_SYS_CLK_DIVIDER_MSB:`SCS_SYS_CLK_DIVIDER_LSB];

  // assemble the readable image
  assign ctl_image = {slow_source_sel_reg,
                      fast_source_sel_reg,
                      slow_clk_halt_en_reg,
                      idle_periph_clk_stop_reg,
                      fast_osc_stop_reg,
                      sys_clk_fast_sel_reg,
                      sys_clk_divider_reg};

  // address decode for the single control register
  always @* begin
    ctl_wr = 1'b0;
    ctl_rd = 1'b0;
    if (REG_WR_IN && ctl_hit) begin
      // write hits the control register
      ctl_wr = 1'b1;
    end else if (REG_RD_IN && ctl_hit) begin
      // read hits the control register
      ctl_rd = 1'b1;
    end
  end

  // restricted fields may only change in their own operating mode;
  // an illegal change is quietly dropped, there is no error flag
  always @* begin
    // default: nothing restricted may change
    slow_source_wr_ok = 1'b0;
    fast_source_wr_ok = 1'b0;
    fast_osc_stop_wr_ok = 1'b0;
    sys_clk_sel_wr_ok = 1'b0;
    if (ctl_wr) begin
      // slow source only while the fast clock drives the system
      slow_source_wr_ok = fast_mode;
      // fast source only while the slow clock drives the system
      fast_source_wr_ok = slow_mode;
      // fast stop only while the slow clock is selected
      fast_osc_stop_wr_ok = slow_mode;
      // system select only while the fast oscillator may run
      sys_clk_sel_wr_ok = fast_osc_free;
    end
  end

  // write filtering: a restricted bit keeps its value when its mode is
  // not active, while the unrestricted bits of the same write land
  always @* begin
    // default: hold every field
    slow_source_sel_next = slow_source_sel_reg;
    fast_source_sel_next = fast_source_sel_reg;
    slow_clk_halt_en_next = slow_clk_halt_en_reg;
    idle_periph_clk_stop_next = idle_periph_clk_stop_reg;
    fast_osc_stop_next = fast_osc_stop_reg;
    sys_clk_fast_sel_next = sys_clk_fast_sel_reg;
    sys_clk_divider_next = sys_clk_divider_reg;
    if (ctl_wr) begin
      // slow source lands only when permitted
      if (slow_source_wr_ok) begin
        slow_source_sel_next = wr_slow_source_sel;
      end
      // fast source lands only when permitted
      if (fast_source_wr_ok) begin
        fast_source_sel_next = wr_fast_source_sel;
      end
      // unrestricted gating controls always land
      slow_clk_halt_en_next = wr_slow_clk_halt_en;
      idle_periph_clk_stop_next = wr_idle_periph_clk_stop;
      // fast stop lands only when permitted
      if (fast_osc_stop_wr_ok) begin
        fast_osc_stop_next = wr_fast_osc_stop;
      end
      // system select lands only when permitted
      if (sys_clk_sel_wr_ok) begin
        sys_clk_fast_sel_next = wr_sys_clk_fast_sel;
      end
      // prescaler code always writable
      sys_clk_divider_next = wr_sys_clk_divider;
    end
  end

  // control register storage, frozen while the clock enable is low
  always @(posedge MCLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      slow_source_sel_reg <= 1'b0;
      fast_source_sel_reg <= 1'b0;
      slow_clk_halt_en_reg <= 1'b0;
      idle_periph_clk_stop_reg <= 1'b0;
      fast_osc_stop_reg <= 1'b0;
      sys_clk_fast_sel_reg <= 1'b0;
      sys_clk_divider_reg <= `SCS_DIVIDER_RESET;
    end else if (CE_IN) begin
      slow_source_sel_reg <= slow_source_sel_next;
      fast_source_sel_reg <= fast_source_sel_next;
      slow_clk_halt_en_reg <= slow_clk_halt_en_next;
      idle_periph_clk_stop_reg <= idle_periph_clk_stop_next;
      fast_osc_stop_reg <= fast_osc_stop_next;
      sys_clk_fast_sel_reg <= sys_clk_fast_sel_next;
      sys_clk_divider_reg <= sys_clk_divider_next;
    end
  end

  // read data: valid only in the cycle after the read strobe,
  // zero otherwise and for unmapped addresses
  always @(posedge MCLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      REG_RDATA_OUT <= `SCS_RDATA_IDLE;
    end else if (CE_IN) begin
      if (ctl_rd) begin
        // mapped read returns the live image
        REG_RDATA_OUT <= ctl_image;
      end else begin
        // no read or unmapped address
        REG_RDATA_OUT <= `SCS_RDATA_IDLE;
      end
    end
  end

  // gating decisions from the fields and the core's mode
  always @* begin
    // slow oscillator halts once power-down is entered with halt enabled
    slow_halt_req = slow_clk_halt_en_reg && POWER_DOWN_BIT_IN;
    // fast oscillator stops in slow mode or idle when its stop bit is set
    fast_stop_req = fast_osc_stop_reg && (slow_mode || IDLE_MODE_IN);
    // serial port and timer clocks gated during idle
    periph_gate_req = idle_periph_clk_stop_reg && IDLE_MODE_IN;
    // run enables are the inverse of the requests
    slow_run_next = !slow_halt_req;
    fast_run_next = !fast_stop_req;
    periph_en_next = !periph_gate_req;
  end

  // crystal pin and gain controls follow the source selectors
  always @* begin
    // a set selector turns its two port pins into crystal pins
    slow_xtal_next = slow_source_sel_reg;
    fast_xtal_next = fast_source_sel_reg;
    // the fast crystal is always driven with the high gain setting
    fast_gain_next = fast_source_sel_reg;
  end

  // registered crystal pin controls, so the pins never see a glitch
  always @(posedge MCLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      // both sources start on their internal rc oscillators
      SLOW_CRYSTAL_EN_OUT <= 1'b0;
      FAST_CRYSTAL_EN_OUT <= 1'b0;
      FAST_XTAL_HIGH_GAIN_OUT <= 1'b0;
    end else if (CE_IN) begin
      SLOW_CRYSTAL_EN_OUT <= slow_xtal_next;
      FAST_CRYSTAL_EN_OUT <= fast_xtal_next;
      FAST_XTAL_HIGH_GAIN_OUT <= fast_gain_next;
    end
  end

  // registered oscillator run enables; both oscillators run out of reset
  always @(posedge MCLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      SLOW_OSC_RUN_OUT <= 1'b1;
      FAST_OSC_RUN_OUT <= 1'b1;
    end else if (CE_IN) begin
      SLOW_OSC_RUN_OUT <= slow_run_next;
      FAST_OSC_RUN_OUT <= fast_run_next;
    end
  end

  // registered clock-tree controls
  always @(posedge MCLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      // slow clock selected, peripherals clocked
      SYS_CLK_FAST_SEL_OUT <= 1'b0;
      PERIPH_CLK_EN_OUT <= 1'b1;
    end else if (CE_IN) begin
      // system clock mux select
      SYS_CLK_FAST_SEL_OUT <= sys_clk_fast_sel_reg;
      // peripheral clock enable
      PERIPH_CLK_EN_OUT <= periph_en_next;
    end
  end

  // prescaler on the selected clock; its tick is a flip-flop output
  scs_prescaler #(
    .CNT_W(4)
  ) u_prescaler (
    .clk_in(MCLK_IN),
    .rst_in(RST_IN),
    .ce_in(CE_IN),
    .div_code_in(sys_clk_divider_reg),
    .tick_out(SYS_CLK_TICK_OUT)
  );

endmodule

// *** src/scs_consts.vh ***
// constants for the system clock select control block
`ifndef SCS_CONSTS_VH
`define SCS_CONSTS_VH

// register map (byte address on the register port)
`define SCS_ADDR_W 8
`define SCS_DATA_W 8
`define SCS_CLOCK_CONTROL_ADDR 8'hD8

// clock_control field positions
`define SCS_SLOW_SOURCE_SEL_BIT 7
`define SCS_FAST_SOURCE_SEL_BIT 6
`define SCS_SLOW_CLK_HALT_EN_BIT 5
`define SCS_IDLE_PERIPH_CLK_STOP_BIT 4
`define SCS_FAST_OSC_STOP_BIT 3
`define SCS_SYS_CLK_FAST_SEL_BIT 2
`define SCS_SYS_CLK_DIVIDER_MSB 1
`define SCS_SYS_CLK_DIVIDER_LSB 0

// reset values
`define SCS_DIVIDER_RESET 2'h3
`define SCS_RDATA_IDLE 8'h00

// divider codes and the ratios they select
`define SCS_DIV_CODE_16 2'h0
`define SCS_DIV_CODE_4 2'h1
`define SCS_DIV_CODE_2 2'h2
`define SCS_DIV_CODE_1 2'h3
`define SCS_DIV_TERM_16 4'hF
`define SCS_DIV_TERM_4 4'h3
`define SCS_DIV_TERM_2 4'h1
`define SCS_DIV_TERM_1 4'h0

// longest delay before a new ratio applies, in clock cycles
`define SCS_DIV_SETTLE_CYCLES 16

`endif

// *** src/scs_prescaler.v ***
// system clock prescaler producing a one-cycle tick every 1, 2, 4 or 16 cycles
`timescale 1ns/1ps
`include "scs_consts.vh"

module scs_prescaler #(
  parameter CNT_W = 4
) (
  // clock, reset and freeze
  input wire clk_in,
  input wire rst_in,
  input wire ce_in,
  // ratio code from the control register
  input wire [1:0] div_code_in,
  // divided system clock enable
  output reg tick_out
);

  // running count and the terminal value in force
  reg [CNT_W-1:0] cnt_reg;
  reg [CNT_W-1:0] term_reg;
  // terminal value decoded from the code
  reg [CNT_W-1:0] term_next;

  // decode the requested ratio
  always @* begin
    case (div_code_in)
      `SCS_DIV_CODE_16: term_next = `SCS_DIV_TERM_16;
      `SCS_DIV_CODE_4: term_next = `SCS_DIV_TERM_4;
      `SCS_DIV_CODE_2: term_next = `SCS_DIV_TERM_2;
      default: term_next = `SCS_DIV_TERM_1;
    endcase
  end

  // count up; a new ratio is only taken at the wrap so ticks never glitch,
  // and since a period is at most 16 cycles it applies within 16 cycles
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_reg <= {CNT_W{1'b0}};
      term_reg <= `SCS_DIV_TERM_1;
      tick_out <= 1'b0;
    end else if (ce_in) begin
      if (cnt_reg >= term_reg) begin
        cnt_reg <= {CNT_W{1'b0}};
        term_reg <= term_next;
        tick_out <= 1'b1;
      end else begin
        cnt_reg <= cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};
        tick_out <= 1'b0;
      end
    end
  end

endmodule

// *** sim/scs_clock_control_props.sv ***
// assertion checker for the clock control block
`timescale 1ns/1ps
`include "scs_consts.vh"
module scs_clock_control_props (
  // clock, reset and enable
  input wire logic MCLK_IN,
  input wire logic RST_IN,
  input wire logic CE_IN,
  // register port and mode inputs
  input wire logic [7:0] REG_ADDR_IN,
  input wire logic REG_RD_IN,
  input wire logic [7:0] REG_RDATA_OUT,
  input wire logic POWER_DOWN_BIT_IN,
  input wire logic IDLE_MODE_IN,
  // clock controls
  input wire logic SLOW_CRYSTAL_EN_OUT,
  input wire logic SLOW_OSC_RUN_OUT,
  input wire logic FAST_CRYSTAL_EN_OUT,
  input wire logic FAST_XTAL_HIGH_GAIN_OUT,
  input wire logic FAST_OSC_RUN_OUT,
  input wire logic SYS_CLK_FAST_SEL_OUT,
  input wire logic SYS_CLK_TICK_OUT,
  input wire logic PERIPH_CLK_EN_OUT
);
  default clocking @(posedge MCLK_IN); endclocking
  default disable iff (RST_IN);
  // slow source frozen while slow clock is selected
  a_slow_src_lock: assert property (!SYS_CLK_FAST_SEL_OUT |=> $stable(SLOW_CRYSTAL_EN_OUT))
    else $error("slow source changed in slow mode");
  a_fast_src_lock: assert property (SYS_CLK_FAST_SEL_OUT |=> $stable(FAST_CRYSTAL_EN_OUT))
    else $error("fast source changed in fast mode");
  a_gain_follows: assert property (FAST_XTAL_HIGH_GAIN_OUT == FAST_CRYSTAL_EN_OUT)
    else $error("gain differs from fast crystal select");
  a_slow_runs: assert property (CE_IN && !POWER_DOWN_BIT_IN |=> SLOW_OSC_RUN_OUT)
    else $error("slow clock halted without power-down");
  a_periph_runs: assert property (CE_IN && !IDLE_MODE_IN |=> PERIPH_CLK_EN_OUT)
    else $error("peripheral clocks gated outside idle");
  a_fast_runs: assert property (CE_IN && !IDLE_MODE_IN ##1 SYS_CLK_FAST_SEL_OUT |-> FAST_OSC_RUN_OUT)
    else $error("fast oscillator stopped in fast mode");
  a_sel_lock: assert property (!FAST_OSC_RUN_OUT |=> $stable(SYS_CLK_FAST_SEL_OUT))
    else $error("clock select changed while fast stopped");
  a_tick_bound: assert property (disable iff (RST_IN || !CE_IN) SYS_CLK_TICK_OUT |-> ##[1:16] SYS_CLK_TICK_OUT)
    else $error("tick gap above sixteen cycles");
  a_rdata_idle: assert property (CE_IN && !(REG_RD_IN && REG_ADDR_IN == `SCS_CLOCK_CONTROL_ADDR) |=>
    REG_RDATA_OUT == 8'h00) else $error("read data not idle");
  // main scenarios reached
  c_tick_pulse: cover property (SYS_CLK_TICK_OUT ##1 !SYS_CLK_TICK_OUT);
  c_fast_stop: cover property (!FAST_OSC_RUN_OUT);
  c_periph_gate: cover property (!PERIPH_CLK_EN_OUT && !SLOW_OSC_RUN_OUT);
endmodule
bind scs_clock_control scs_clock_control_props scs_clock_control_props_i (.MCLK_IN(MCLK_IN), .RST_IN(RST_IN),
  .CE_IN(CE_IN), .REG_ADDR_IN(REG_ADDR_IN), .REG_RD_IN(REG_RD_IN), .REG_RDATA_OUT(REG_RDATA_OUT),
  .POWER_DOWN_BIT_IN(POWER_DOWN_BIT_IN), .IDLE_MODE_IN(IDLE_MODE_IN), .SLOW_CRYSTAL_EN_OUT(SLOW_CRYSTAL_EN_OUT),
  .SLOW_OSC_RUN_OUT(SLOW_OSC_RUN_OUT), .FAST_CRYSTAL_EN_OUT(FAST_CRYSTAL_EN_OUT),
  .FAST_XTAL_HIGH_GAIN_OUT(FAST_XTAL_HIGH_GAIN_OUT), .FAST_OSC_RUN_OUT(FAST_OSC_RUN_OUT),
  .SYS_CLK_FAST_SEL_OUT(SYS_CLK_FAST_SEL_OUT), .SYS_CLK_TICK_OUT(SYS_CLK_TICK_OUT),
  .PERIPH_CLK_EN_OUT(PERIPH_CLK_EN_OUT));

// *** sim/scs_clock_control_tb.sv ***
// self-checking bench for the clock control block
`timescale 1ns/1ps
`include "scs_consts.vh"
module scs_clock_control_tb;
  // stimulus
  logic clk = 0, rst = 1, ce = 1, wr = 0, rd = 0, pd = 0, idle = 0;
  logic [7:0] addr = 8'h00, wdat = 8'h00;
  // design outputs
  wire [7:0] rdat;
  wire sxe, sor, fxe, fhg, fru, sel, tick, pce;
  int n_fail = 0, cmp_count = 0, n;
  // rows: write value, expected image, expected tick period
  logic [7:0] wv [6] = '{8'h04, 8'hC5, 8'h0A, 8'hCB, 8'h4C, 8'h33};
  logic [7:0] ev [6] = '{8'h04, 8'h85, 8'h02, 8'h4B, 8'h48, 8'h33};
  logic [7:0] pv [6] = '{8'h10, 8'h04, 8'h02, 8'h01, 8'h10, 8'h01};
  scs_clock_control scs_clock_control_i (.MCLK_IN(clk), .RST_IN(rst), .CE_IN(ce), .REG_ADDR_IN(addr),
    .REG_WDATA_IN(wdat), .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdat), .POWER_DOWN_BIT_IN(pd),
    .IDLE_MODE_IN(idle), .SLOW_CRYSTAL_EN_OUT(sxe), .SLOW_OSC_RUN_OUT(sor), .FAST_CRYSTAL_EN_OUT(fxe),
    .FAST_XTAL_HIGH_GAIN_OUT(fhg), .FAST_OSC_RUN_OUT(fru), .SYS_CLK_FAST_SEL_OUT(sel),
    .SYS_CLK_TICK_OUT(tick), .PERIPH_CLK_EN_OUT(pce));
  // 25 MHz clock
  always #20 clk = ~clk;
  // report counts and verdict, then stop
  task conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // compare seen against expected
  task chk(input string nm, input logic [7:0] s, e);
    cmp_count++;
    if (s !== e) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask
  // one-cycle register write
  task wrt(input logic [7:0] a, d);
    @(posedge clk);
    addr <= a;
    wdat <= d;
    wr <= 1;
    @(posedge clk);
    wr <= 0;
  endtask
  // one-cycle read, data checked in the following cycle
  task rdc(input logic [7:0] a, e);
    @(posedge clk);
    addr <= a;
    rd <= 1;
    @(posedge clk);
    rd <= 0;
    #1 chk("read data", rdat, e);
  endtask
  // cycles from one tick to the next, bounded
  task meas(output int c);
    int k;
    k = 0;
    while (tick !== 1'b1 && k < 40) begin
      @(posedge clk);
      #1 k++;
    end
    c = 0;
    do begin
      @(posedge clk);
      #1 c++;
    end while (tick !== 1'b1 && c < 40);
    if (c >= 40 || k >= 40) begin
      n_fail++;
      conclude();
    end
  endtask
  // main sequence
  initial begin
    repeat (3) @(posedge clk);
    rst <= 0;
    #1 chk("reset outputs", {sxe, sor, fxe, fhg, fru, sel, pce, 1'b0}, 8'h4A);
    rdc(8'hD8, 8'h03);
    meas(n);
    chk("reset period", 8'(n), 8'h01);
    for (int i = 0; i < 6; i++) begin
      wrt(8'hD8, wv[i]);
      rdc(8'hD8, ev[i]);
      chk("osc controls", {sxe, fxe, fhg, sel, fru, 3'h0},
        {ev[i][7], ev[i][6], ev[i][6], ev[i][2], !(ev[i][3] && !ev[i][2]), 3'h0});
      meas(n);
      meas(n);
      chk("tick period", 8'(n), pv[i]);
    end
    // power-down and idle with slow halt and peripheral stop set, then fast stop
    @(posedge clk);
    pd <= 1;
    idle <= 1;
    repeat (2) @(posedge clk);
    #1 chk("gating", {sor, pce, fru, 5'h00}, 8'h20);
    wrt(8'hD8, 8'h3B);
    rdc(8'hD8, 8'h3B);
    chk("fast stop", {7'h00, fru}, 8'h00);
    @(posedge clk);
    pd <= 0;
    idle <= 0;
    // unmapped address is ignored and reads zero
    wrt(8'hD9, 8'h00);
    rdc(8'hD8, 8'h3B);
    rdc(8'hD9, 8'h00);
    // clock enable low freezes the register against a write
    @(posedge clk);
    ce <= 0;
    wrt(8'hD8, 8'h00);
    @(posedge clk);
    ce <= 1;
    rdc(8'hD8, 8'h3B);
    // fast mode with the fast stop set: fast runs until idle
    wrt(8'hD8, 8'h33);
    wrt(8'hD8, 8'h3F);
    rdc(8'hD8, 8'h3F);
    chk("fast mode run", {6'h00, sel, fru}, 8'h03);
    @(posedge clk);
    idle <= 1;
    repeat (2) @(posedge clk);
    #1 chk("idle fast stop", {6'h00, fru, pce}, 8'h00);
    // select and stop lock each other; other fields still land
    wrt(8'hD8, 8'h30);
    rdc(8'hD8, 8'h3C);
    // second reset mid-run
    @(posedge clk);
    idle <= 0;
    rst <= 1;
    @(posedge clk);
    rst <= 0;
    #1 chk("reset outputs", {sxe, sor, fxe, fhg, fru, sel, pce, 1'b0}, 8'h4A);
    rdc(8'hD8, 8'h03);
    conclude();
  end
endmodule
